/* File: rtl/pib_pkg.sv */
package pib_pkg;
  // data-memory offsets of the mapped registers
  localparam logic [5:0] PIB_ADDR_PC_HIGH_BUFFER = 6'h0a;
  localparam logic [5:0] PIB_ADDR_PULL_DOWN      = 6'h0b;
  localparam logic [5:0] PIB_ADDR_OPEN_DRAIN     = 6'h0c;
  localparam logic [5:0] PIB_ADDR_PULL_HIGH      = 6'h0d;
  localparam logic [5:0] PIB_ADDR_IRQ_MASK       = 6'h0e;
  localparam logic [5:0] PIB_ADDR_IRQ_FLAGS      = 6'h0f;
  // direction-load operands
  localparam logic [5:0] PIB_ADDR_PORT_A         = 6'h05;
  localparam logic [5:0] PIB_ADDR_PORT_B         = 6'h06;
  // interrupt vector
  localparam logic [9:0] PIB_IRQ_VECTOR          = 10'h008;
  // field positions
  localparam int PIB_BIT_TIMER_IRQ       = 0;
  localparam int PIB_BIT_PORTB_IRQ       = 1;
  localparam int PIB_BIT_EXT_IRQ         = 2;
  localparam int PIB_BIT_GLOBAL_EN       = 7;
  localparam int PIB_BIT_PRESCALE_ASSIGN = 3;
  localparam int PIB_BIT_TIMER_EDGE      = 4;
  localparam int PIB_BIT_TIMER_SOURCE    = 5;
  localparam int PIB_BIT_EDGE            = 6;
  // implemented-bit masks
  localparam logic [7:0] PIB_MASK_IRQ_MASK  = 8'h87;
  localparam logic [7:0] PIB_MASK_IRQ_FLAGS = 8'h07;
  // reset values
  localparam logic [7:0] PIB_RST_PC_HIGH    = 8'h00;
  localparam logic [7:0] PIB_RST_PULL_DOWN  = 8'hff;
  localparam logic [7:0] PIB_RST_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] PIB_RST_PULL_HIGH  = 8'hff;
  localparam logic [7:0] PIB_RST_IRQ_MASK   = 8'h00;
  localparam logic [7:0] PIB_RST_IRQ_FLAGS  = 8'h00;
  localparam logic [7:0] PIB_RST_ACCUM      = 8'h00;
  localparam logic [6:0] PIB_RST_CONFIG     = 7'h3f;
  localparam logic [7:0] PIB_RST_DIRECTION  = 8'hff;
endpackage : pib_pkg

/* File: rtl/pib_edge_sync.sv */
`timescale 1ns/1ns
// two-flop synchroniser with level output and rise and fall pulses
module pib_edge_sync
  import pib_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // pins
  input  wire logic [WIDTH-1:0] pin_async,
  // synchronised level and edges
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
    logic [2:0]       primed;
  } pib_sync_t;

  pib_sync_t state;
  pib_sync_t next_state;

  // meta is read only by sync
  always_comb begin
    next_state      = state;
    next_state.meta = pin_async;
    next_state.sync = state.meta;
    next_state.last = state.sync;
    next_state.primed = {state.primed[1:0], 1'b1};
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.sync;
  // pin idle level is unknown at reset; no edges until sync and last both hold the pin
  assign rise  = state.sync & ~state.last & {WIDTH{state.primed[2]}};
  assign fall  = ~state.sync & state.last & {WIDTH{state.primed[2]}};
endmodule : pib_edge_sync

/* File: rtl/pib_port_irq_bank.sv */
`timescale 1ns/1ns
module pib_port_irq_bank
  import pib_pkg::*;
#(
  parameter int PC_HIGH_BITS = 2
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // data-memory register access from the core
  input  wire logic [5:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_hit,
  // accumulator and special instructions
  input  wire logic        accum_write,
  input  wire logic [7:0]  accum_wdata,
  output logic      [7:0]  accumulator,
  input  wire logic        option_load,
  input  wire logic        direction_load,
  input  wire logic [5:0]  direction_addr,
  input  wire logic        return_from_irq,
  // program counter control
  input  wire logic        pc_low_write,
  output logic      [1:0]  pc_high_load,
  input  wire logic        sleeping,
  output logic             wake,
  output logic             irq_take,
  output logic      [9:0]  irq_vector,
  // event sources
  input  wire logic        timer_overflow,
  input  wire logic [7:0]  port_b_pin,
  input  wire logic        ext_irq_pin,
  input  wire logic [7:0]  portb_change_enable,
  // configuration outputs
  output logic      [2:0]  prescaler_ratio_select,
  output logic             prescaler_assign,
  output logic             timer_ext_edge_select,
  output logic             timer_clock_source_select,
  output logic             ext_irq_edge_select,
  // pad controls
  output logic      [7:0]  port_a_direction,
  output logic      [7:0]  port_b_direction,
  output logic      [7:0]  port_a_oe,
  output logic      [7:0]  port_b_oe,
  output logic      [7:0]  portb_pin_opendrain,
  output logic      [3:0]  porta_pin_pulldown_en,
  output logic      [3:0]  portb_pin_pulldown_en,
  output logic      [7:0]  portb_pin_pullhigh_en
);
  typedef struct packed {
    logic [7:0] pc_high_buffer;
    logic [7:0] pull_down_control;
    logic [7:0] open_drain_control;
    logic [7:0] pull_high_control;
    logic [7:0] interrupt_mask;
    logic [7:0] interrupt_flags;
    logic [7:0] accumulator;
    logic [6:0] config_reg;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] rdata;
    logic       hit;
  } pib_bank_t;

  localparam logic [7:0] PC_HIGH_MASK = 8'((1 << PC_HIGH_BITS) - 1);

  pib_bank_t  state;
  pib_bank_t  next_state;
  logic [7:0] pb_level;
  logic [7:0] pb_rise;
  logic [7:0] pb_fall;
  logic [0:0] ext_level;
  logic [0:0] ext_rise;
  logic [0:0] ext_fall;
  logic [2:0] events;
  logic [2:0] armed;

  // pins cross into clk_sys before any edge logic
  pib_edge_sync #(.WIDTH(8)) u_pb_sync (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .pin_async (port_b_pin),
    .level     (pb_level),
    .rise      (pb_rise),
    .fall      (pb_fall)
  );

  pib_edge_sync #(.WIDTH(1)) u_ext_sync (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .pin_async (ext_irq_pin),
    .level     (ext_level),
    .rise      (ext_rise),
    .fall      (ext_fall)
  );

  // hardware events; output pins are excluded from change detection
  always_comb begin
    events[PIB_BIT_TIMER_IRQ] = timer_overflow;
    events[PIB_BIT_PORTB_IRQ] = |((pb_rise | pb_fall) & portb_change_enable
                                  & state.port_b_direction);
    events[PIB_BIT_EXT_IRQ]   = state.config_reg[PIB_BIT_EDGE] ? ext_rise[0]
                                                               : ext_fall[0];
  end

  // sources that are enabled and pending
  assign armed    = (state.interrupt_flags[2:0] | events) & state.interrupt_mask[2:0];
  assign irq_take = state.interrupt_mask[PIB_BIT_GLOBAL_EN] && (armed != 3'h0);
  // wake needs only the source enable; global enable picks resume point
  assign wake       = sleeping && (armed != 3'h0);
  assign irq_vector = PIB_IRQ_VECTOR;

  always_comb begin
    next_state       = state;
    next_state.hit   = 1'b0;
    next_state.rdata = 8'h00;
    // register write from the core
    if (reg_write) begin
      unique case (reg_addr)
        PIB_ADDR_PC_HIGH_BUFFER: next_state.pc_high_buffer = reg_wdata & PC_HIGH_MASK;
        PIB_ADDR_PULL_DOWN:      next_state.pull_down_control = reg_wdata;
        PIB_ADDR_OPEN_DRAIN:     next_state.open_drain_control = reg_wdata;
        PIB_ADDR_PULL_HIGH:      next_state.pull_high_control = reg_wdata;
        PIB_ADDR_IRQ_MASK:       next_state.interrupt_mask = reg_wdata & PIB_MASK_IRQ_MASK;
        PIB_ADDR_IRQ_FLAGS:      next_state.interrupt_flags = reg_wdata & PIB_MASK_IRQ_FLAGS;
        default: ;
      endcase
    end
    // hardware sets win over a software clear in the same cycle
    next_state.interrupt_flags[2:0] = next_state.interrupt_flags[2:0] | events;
    // return re-enables, a taken interrupt clears; take has priority
    if (return_from_irq) begin
      next_state.interrupt_mask[PIB_BIT_GLOBAL_EN] = 1'b1;
    end
    if (irq_take) begin
      next_state.interrupt_mask[PIB_BIT_GLOBAL_EN] = 1'b0;
    end
    // accumulator is reachable only through this port
    if (accum_write) begin
      next_state.accumulator = accum_wdata;
    end
    if (option_load) begin
      next_state.config_reg = state.accumulator[6:0];
    end
    if (direction_load && direction_addr == PIB_ADDR_PORT_A) begin
      next_state.port_a_direction = state.accumulator;
    end
    if (direction_load && direction_addr == PIB_ADDR_PORT_B) begin
      next_state.port_b_direction = state.accumulator;
    end
    // registered read data, one cycle after the address
    next_state.hit = 1'b1;
    unique case (reg_addr)
      PIB_ADDR_PC_HIGH_BUFFER: next_state.rdata = state.pc_high_buffer;
      PIB_ADDR_PULL_DOWN:      next_state.rdata = state.pull_down_control;
      PIB_ADDR_OPEN_DRAIN:     next_state.rdata = state.open_drain_control;
      PIB_ADDR_PULL_HIGH:      next_state.rdata = state.pull_high_control;
      PIB_ADDR_IRQ_MASK:       next_state.rdata = state.interrupt_mask;
      PIB_ADDR_IRQ_FLAGS:      next_state.rdata = state.interrupt_flags & state.interrupt_mask;
      default:                 next_state.hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state.pc_high_buffer     <= PIB_RST_PC_HIGH;
      state.pull_down_control  <= PIB_RST_PULL_DOWN;
      state.open_drain_control <= PIB_RST_OPEN_DRAIN;
      state.pull_high_control  <= PIB_RST_PULL_HIGH;
      state.interrupt_mask     <= PIB_RST_IRQ_MASK;
      state.interrupt_flags    <= PIB_RST_IRQ_FLAGS;
      state.accumulator        <= PIB_RST_ACCUM;
      state.config_reg         <= PIB_RST_CONFIG;
      state.port_a_direction   <= PIB_RST_DIRECTION;
      state.port_b_direction   <= PIB_RST_DIRECTION;
      state.rdata              <= 8'h00;
      state.hit                <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // outputs
  assign reg_rdata    = state.rdata;
  assign reg_hit      = state.hit;
  assign accumulator  = state.accumulator;
  // only the buffer feeds pc high; it is never written back
  assign pc_high_load = pc_low_write ? state.pc_high_buffer[1:0] : 2'h0;

  assign prescaler_ratio_select    = state.config_reg[2:0];
  assign prescaler_assign          = state.config_reg[PIB_BIT_PRESCALE_ASSIGN];
  assign timer_ext_edge_select     = state.config_reg[PIB_BIT_TIMER_EDGE];
  assign timer_clock_source_select = state.config_reg[PIB_BIT_TIMER_SOURCE];
  assign ext_irq_edge_select       = state.config_reg[PIB_BIT_EDGE];

  assign port_a_direction = state.port_a_direction;
  assign port_b_direction = state.port_b_direction;
  assign port_a_oe        = ~state.port_a_direction;
  assign port_b_oe        = ~state.port_b_direction;
  // open drain only matters while driving
  assign portb_pin_opendrain = state.open_drain_control & ~state.port_b_direction;
  // weak pulls turn off on output pins
  assign porta_pin_pulldown_en = ~state.pull_down_control[3:0]
                                 & state.port_a_direction[3:0];
  assign portb_pin_pulldown_en = ~state.pull_down_control[7:4]
                                 & state.port_b_direction[3:0];
  assign portb_pin_pullhigh_en = ~state.pull_high_control
                                 & state.port_b_direction;

  // checks
  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    timer_overflow |=> state.interrupt_flags[0])
    else $error("timer flag not set");
  flag_read_and_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_addr == PIB_ADDR_IRQ_FLAGS) |=> reg_rdata == ($past(state.interrupt_flags)
                                                      & $past(state.interrupt_mask)))
    else $error("flag read not masked");
  global_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq_take |=> !state.interrupt_mask[7])
    else $error("global enable not cleared");
  global_return_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (return_from_irq && !irq_take) |=> state.interrupt_mask[7])
    else $error("return did not set global enable");
  option_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    option_load |=> state.config_reg == $past(state.accumulator[6:0]))
    else $error("option load wrong");
  dir_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (direction_load && direction_addr == PIB_ADDR_PORT_B)
      |=> port_b_direction == $past(state.accumulator))
    else $error("direction load wrong");
  pullhigh_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (portb_pin_pullhigh_en & port_b_oe) == 8'h00)
    else $error("pull-high on output");
  pulldown_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (porta_pin_pulldown_en & port_a_oe[3:0]) == 4'h0)
    else $error("pull-down on output");
  mask_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state.interrupt_mask[6:3] == 4'h0 && state.interrupt_flags[7:3] == 5'h00)
    else $error("reserved bits set");
  pc_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_write && reg_addr == PIB_ADDR_PC_HIGH_BUFFER) ##1 pc_low_write
      |-> pc_high_load == ($past(reg_wdata[1:0]) & PC_HIGH_MASK[1:0]))
    else $error("pc high not from buffer");

  // write path: each mapped register except the flag register takes the written byte, reserved bits dropped
  pd_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_write && reg_addr == PIB_ADDR_PULL_DOWN) |=> state.pull_down_control == $past(reg_wdata))
    else $error("pull-down write lost");
  od_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_write && reg_addr == PIB_ADDR_OPEN_DRAIN) |=> state.open_drain_control == $past(reg_wdata))
    else $error("open-drain write lost");
  ph_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_write && reg_addr == PIB_ADDR_PULL_HIGH) |=> state.pull_high_control == $past(reg_wdata))
    else $error("pull-high write lost");
  pc_buf_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_write && reg_addr == PIB_ADDR_PC_HIGH_BUFFER)
      |=> state.pc_high_buffer == ($past(reg_wdata) & PC_HIGH_MASK))
    else $error("pc buffer write wrong");
  pc_buf_bits_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state.pc_high_buffer & ~PC_HIGH_MASK) == 8'h00)
    else $error("pc buffer unimplemented bit set");
  mask_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_write && reg_addr == PIB_ADDR_IRQ_MASK && !irq_take && !return_from_irq)
      |=> state.interrupt_mask == ($past(reg_wdata) & PIB_MASK_IRQ_MASK))
    else $error("mask write wrong");

  // flags only fall on a software write to the flag register
  flag_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !(reg_write && reg_addr == PIB_ADDR_IRQ_FLAGS)
      |=> ($past(state.interrupt_flags) & ~state.interrupt_flags) == 8'h00)
    else $error("flag cleared by hardware");
  pb_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    events[PIB_BIT_PORTB_IRQ] |=> state.interrupt_flags[PIB_BIT_PORTB_IRQ])
    else $error("port b flag not set");
  ext_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (ext_irq_edge_select ? ext_rise[0] : ext_fall[0]) |=> state.interrupt_flags[PIB_BIT_EXT_IRQ])
    else $error("ext pin flag not set");

  // wake and take follow pending enabled flags
  wake_level_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (sleeping && (state.interrupt_flags[2:0] & state.interrupt_mask[2:0]) != 3'h0) |-> wake)
    else $error("no wake on pending source");
  take_level_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state.interrupt_mask[7] && (state.interrupt_flags[2:0] & state.interrupt_mask[2:0]) != 3'h0)
      |-> irq_take)
    else $error("enabled pending source not taken");
  take_single_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq_take |=> !irq_take)
    else $error("interrupt taken twice");
  vector_const_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq_take |-> irq_vector == 10'h008)
    else $error("wrong interrupt vector");

  // accumulator, port a direction and pad gating
  accum_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    accum_write |=> accumulator == $past(accum_wdata))
    else $error("accumulator load wrong");
  dir_a_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (direction_load && direction_addr == PIB_ADDR_PORT_A)
      |=> port_a_direction == $past(state.accumulator))
    else $error("port a direction load wrong");
  opendrain_input_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (portb_pin_opendrain & ~port_b_oe) == 8'h00)
    else $error("open drain on input");
  pulldown_b_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (portb_pin_pulldown_en & port_b_oe[3:0]) == 4'h0)
    else $error("port b pull-down on output");

  irq_taken_c:   cover property (@(posedge clk_sys) disable iff (!reset_n) irq_take);
  wake_resume_c: cover property (@(posedge clk_sys) disable iff (!reset_n) wake && !irq_take);
  pb_change_c:   cover property (@(posedge clk_sys) disable iff (!reset_n) events[PIB_BIT_PORTB_IRQ]);
  return_seen_c: cover property (@(posedge clk_sys) disable iff (!reset_n) return_from_irq && !irq_take);
  clear_race_c:  cover property (@(posedge clk_sys) disable iff (!reset_n)
    reg_write && reg_addr == PIB_ADDR_IRQ_FLAGS && timer_overflow);
endmodule : pib_port_irq_bank

/* File: bench/pib_pin_model.sv */
`timescale 1ns/1ns
// far side of the bank: port b pins, external irq pin, timer overflow event
module pib_pin_model (
  // clock
  input  wire logic       clk_sys,
  // pins and events towards the bank
  output logic      [7:0] port_b_pin,
  output logic            ext_irq_pin,
  output logic            timer_overflow
);
  // pins idle high as if pulled up, overflow idle low
  initial begin
    port_b_pin     = 8'hff;
    ext_irq_pin    = 1'b1;
    timer_overflow = 1'b0;
  end
  // pins move just after an edge; the bank synchronises them itself
  task automatic set_pins(input logic [7:0] b, input logic e);
    @(posedge clk_sys);
    #1;
    port_b_pin  = b;
    ext_irq_pin = e;
  endtask : set_pins
  // overflow is one cycle wide, same clock as the bank
  task automatic overflow();
    @(posedge clk_sys);
    #1 timer_overflow = 1'b1;
    @(posedge clk_sys);
    #1 timer_overflow = 1'b0;
  endtask : overflow
endmodule : pib_pin_model

/* File: bench/test_port_irq_option_register_bank.sv */
`timescale 1ns/1ns
module test_port_irq_option_register_bank
  import pib_pkg::*;
;
  logic       clk_sys = 1'b0, reset_n = 1'b0;
  logic [5:0] reg_addr = 6'h00, direction_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00, accum_wdata = 8'h00, reg_rdata, accumulator;
  logic       reg_write = 1'b0, accum_write = 1'b0, option_load = 1'b0, direction_load = 1'b0;
  logic       return_from_irq = 1'b0, pc_low_write = 1'b0, sleeping = 1'b0;
  logic       reg_hit, wake, irq_take, timer_overflow, ext_irq_pin;
  logic [1:0] pc_high_load;
  logic [9:0] irq_vector, vec = 10'h000;
  logic [7:0] port_b_pin, dir_a, dir_b, oe_a, oe_b, od_b, ph_b;
  logic [3:0] pd_a, pd_b;
  logic [2:0] ratio;
  logic       pre_assign, tmr_edge, tmr_source, edge_sel;
  int         bad_count = 0, n_compared = 0, takes = 0;
  // table of mapped registers and their values after reset
  logic [5:0] ra [6] = '{PIB_ADDR_PC_HIGH_BUFFER, PIB_ADDR_PULL_DOWN, PIB_ADDR_OPEN_DRAIN,
                         PIB_ADDR_PULL_HIGH, PIB_ADDR_IRQ_MASK, PIB_ADDR_IRQ_FLAGS};
  logic [7:0] rv [6] = '{PIB_RST_PC_HIGH, PIB_RST_PULL_DOWN, PIB_RST_OPEN_DRAIN,
                         PIB_RST_PULL_HIGH, PIB_RST_IRQ_MASK, PIB_RST_IRQ_FLAGS};

  pib_port_irq_bank #(.PC_HIGH_BITS(2)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .accum_write(accum_write),
    .accum_wdata(accum_wdata), .accumulator(accumulator), .option_load(option_load),
    .direction_load(direction_load), .direction_addr(direction_addr),
    .return_from_irq(return_from_irq), .pc_low_write(pc_low_write), .pc_high_load(pc_high_load),
    .sleeping(sleeping), .wake(wake), .irq_take(irq_take), .irq_vector(irq_vector),
    .timer_overflow(timer_overflow), .port_b_pin(port_b_pin), .ext_irq_pin(ext_irq_pin),
    .portb_change_enable(8'hff), .prescaler_ratio_select(ratio), .prescaler_assign(pre_assign),
    .timer_ext_edge_select(tmr_edge), .timer_clock_source_select(tmr_source),
    .ext_irq_edge_select(edge_sel),
    .port_a_direction(dir_a), .port_b_direction(dir_b), .port_a_oe(oe_a), .port_b_oe(oe_b),
    .portb_pin_opendrain(od_b), .porta_pin_pulldown_en(pd_a), .portb_pin_pulldown_en(pd_b),
    .portb_pin_pullhigh_en(ph_b));

  pib_pin_model pins (
    .clk_sys(clk_sys), .port_b_pin(port_b_pin), .ext_irq_pin(ext_irq_pin),
    .timer_overflow(timer_overflow));

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  // irq_take lasts one cycle, so count takes for later comparison
  always @(posedge clk_sys) if (irq_take === 1'b1) begin
    takes <= takes + 1;
    vec  <= irq_vector;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // strobe tasks end one idle cycle later so no strobe is set twice in a step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr = a; reg_wdata = d; reg_write = 1'b1; tick(1); reg_write = 1'b0; tick(1);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    reg_addr = a;
    tick(1);
    chk("reg_rdata", reg_rdata, exp);
    chk("reg_hit", reg_hit, (a >= 6'h0a && a <= 6'h0f));
  endtask : rd
  task automatic ld_accum(input logic [7:0] v);
    accum_wdata = v; accum_write = 1'b1; tick(1); accum_write = 1'b0; tick(1);
  endtask : ld_accum
  task automatic opt(input logic [7:0] v);
    ld_accum(v); option_load = 1'b1; tick(1); option_load = 1'b0; tick(1);
  endtask : opt
  task automatic dload(input logic [5:0] a, input logic [7:0] v);
    ld_accum(v); direction_addr = a; direction_load = 1'b1; tick(1); direction_load = 1'b0; tick(1);
  endtask : dload
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // watchdog: the sequence needs well under two hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    end_of_test();
  end

  initial begin
    tick(2);
    reset_n = 1'b1;
    tick(1);
    // reset state of mapped and write-only registers
    for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
    chk("config", {edge_sel, tmr_source, tmr_edge, pre_assign, ratio}, 7'h3f);
    chk("dir", {dir_a, dir_b, oe_a, oe_b}, 32'hffff_0000);
    chk("accumulator", accumulator, 8'h00);
    // register write and read back, reserved bits and an unmapped place
    wr(PIB_ADDR_PC_HIGH_BUFFER, 8'hff); rd(PIB_ADDR_PC_HIGH_BUFFER, 8'h03);
    chk("pc_high_load", pc_high_load, 2'b00);
    pc_low_write = 1'b1; #1 chk("pc_high_load", pc_high_load, 2'b11);
    tick(1); pc_low_write = 1'b0;
    // buffer write followed at once by a pc low write
    reg_wdata = 8'h02; reg_write = 1'b1; tick(1); reg_write = 1'b0; pc_low_write = 1'b1;
    #1 chk("pc_high_load", pc_high_load, 2'b10);
    tick(1); pc_low_write = 1'b0;
    wr(PIB_ADDR_IRQ_MASK, 8'hff); rd(PIB_ADDR_IRQ_MASK, 8'h87);
    wr(PIB_ADDR_PULL_DOWN, 8'h5a); rd(PIB_ADDR_PULL_DOWN, 8'h5a);
    wr(PIB_ADDR_OPEN_DRAIN, 8'ha5); rd(PIB_ADDR_OPEN_DRAIN, 8'ha5);
    wr(PIB_ADDR_PULL_HIGH, 8'h3c); rd(PIB_ADDR_PULL_HIGH, 8'h3c);
    wr(6'h10, 8'h5a); rd(6'h10, 8'h00);
    // pads: all pins inputs, then a mix of outputs
    wr(PIB_ADDR_IRQ_MASK, 8'h00); wr(PIB_ADDR_PULL_DOWN, 8'h00);
    wr(PIB_ADDR_PULL_HIGH, 8'h00); wr(PIB_ADDR_OPEN_DRAIN, 8'hff);
    chk("pads", {pd_a, pd_b, ph_b, od_b}, 24'hff_ff00);
    dload(PIB_ADDR_PORT_A, 8'h0f); dload(PIB_ADDR_PORT_B, 8'h3c); dload(6'h07, 8'h00);
    chk("dir", {dir_a, oe_a, dir_b, oe_b}, 32'h0ff0_3cc3);
    chk("accumulator", accumulator, 8'h00);
    chk("pads", {pd_a, pd_b, ph_b, od_b}, 24'hfc_3cc3);
    // configuration loads, every field in both states
    opt(8'h55); chk("config", {edge_sel, tmr_source, tmr_edge, pre_assign, ratio}, 7'h55);
    opt(8'h2a); chk("config", {edge_sel, tmr_source, tmr_edge, pre_assign, ratio}, 7'h2a);
    // wake on falling pin edge with global enable clear
    wr(PIB_ADDR_IRQ_MASK, 8'h04); sleeping = 1'b1; pins.set_pins(8'hff, 1'b0); tick(5);
    chk("wake", wake, 1'b1); chk("took", takes, 0);
    sleeping = 1'b0;
    rd(PIB_ADDR_IRQ_FLAGS, 8'h04); wr(PIB_ADDR_IRQ_MASK, 8'h00);
    rd(PIB_ADDR_IRQ_FLAGS, 8'h00); wr(PIB_ADDR_IRQ_MASK, 8'h04);
    rd(PIB_ADDR_IRQ_FLAGS, 8'h04); wr(PIB_ADDR_IRQ_FLAGS, 8'h00);
    // wrong edge ignored, right edge taken with global enable set
    wr(PIB_ADDR_IRQ_MASK, 8'h84); pins.set_pins(8'hff, 1'b1); tick(5);
    chk("took", takes, 0); rd(PIB_ADDR_IRQ_FLAGS, 8'h00);
    pins.set_pins(8'hff, 1'b0); tick(5);
    chk("took", takes, 1); chk("vector", vec, 10'h008);
    rd(PIB_ADDR_IRQ_MASK, 8'h04); wr(PIB_ADDR_IRQ_FLAGS, 8'h00);
    // port b change: input pin counts, output pin does not
    wr(PIB_ADDR_IRQ_MASK, 8'h02); pins.set_pins(8'hfb, 1'b0); tick(5);
    rd(PIB_ADDR_IRQ_FLAGS, 8'h02); wr(PIB_ADDR_IRQ_FLAGS, 8'h00);
    pins.set_pins(8'hfa, 1'b0); tick(5); rd(PIB_ADDR_IRQ_FLAGS, 8'h00);
    // timer overflow taken, flag kept until cleared, return re-enables
    wr(PIB_ADDR_IRQ_MASK, 8'h81); pins.overflow(); tick(2);
    chk("took", takes, 2); rd(PIB_ADDR_IRQ_MASK, 8'h01);
    tick(3); rd(PIB_ADDR_IRQ_FLAGS, 8'h01); wr(PIB_ADDR_IRQ_FLAGS, 8'h00);
    return_from_irq = 1'b1; tick(1); return_from_irq = 1'b0; tick(1);
    rd(PIB_ADDR_IRQ_MASK, 8'h81); rd(PIB_ADDR_IRQ_FLAGS, 8'h00);
    end_of_test();
  end
endmodule : test_port_irq_option_register_bank
